// file: src/mom_pkg.sv
package mom_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned TICK_US = 1000;
   // cycles per 1 ms tick
   localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int unsigned TICKS_PER_SEC = 1000;
   // ------------------------------------------------------------
   // setting ranges and factory defaults
   // ------------------------------------------------------------
   localparam logic [7:0] WARN_LEVEL_MIN = 8'h1e;
   localparam logic [7:0] WARN_LEVEL_MAX = 8'h96;
   localparam logic [7:0] WARN_LEVEL_RST = 8'h96;
   localparam logic [4:0] HOLD_TIME_MAX = 5'h1e;
   localparam logic [4:0] HOLD_TIME_RST = 5'h0a;
   localparam logic TRIP_ENABLE_RST = 1'b1;
   localparam logic [7:0] TRIP_LEVEL_MIN = 8'h1e;
   localparam logic [7:0] TRIP_LEVEL_MAX = 8'hc8;
   localparam logic [7:0] TRIP_LEVEL_RST = 8'hb4;
   localparam logic [5:0] TRIP_TIME_MAX = 6'h3c;
   localparam logic [5:0] TRIP_TIME_RST = 6'h3c;
   localparam logic [3:0] OC_FUNC_OVERLOAD = 4'h5;
   localparam logic [3:0] OC_FUNC_RST = 4'h0;

   // settings as one bundle
   typedef struct packed {
      logic [7:0] warn_level;
      logic [4:0] hold_time;
      logic trip_enable;
      logic [7:0] trip_level;
      logic [5:0] trip_time;
      logic [3:0] oc_func;
      logic relay_sel;
   } mom_cfg_t;

   localparam mom_cfg_t CFG_RST = '{warn_level: WARN_LEVEL_RST, hold_time: HOLD_TIME_RST,
      trip_enable: TRIP_ENABLE_RST, trip_level: TRIP_LEVEL_RST, trip_time: TRIP_TIME_RST,
      oc_func: OC_FUNC_RST, relay_sel: 1'b0};
endpackage : mom_pkg

// file: src/mom_tick.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// periodic tick generator
// ------------------------------------------------------------
module mom_tick
(
   input wire logic core_clk,
   input wire logic rst_b,
   output logic tick
);
   typedef struct packed {
      logic [16:0] cnt;
      logic tick;
   } mom_tick_st_t;

   localparam logic [16:0] LAST = 17'(mom_pkg::TICK_CYCLES - 1);

   mom_tick_st_t st;
   mom_tick_st_t next_st;

   // count up one tick period
   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == LAST)
      begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt + 17'h00001;
      end
   end

   // state register
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick = st.tick;
endmodule : mom_tick
`default_nettype wire

// file: src/mom_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - warning hold time is settable 0 to 30 s and defaults to 10 s.
// - the alarm is raised when measured current reaches the warning level.
// - the alarm stays on for the hold time after current falls below the level.
// - warning level is a percentage of rated motor current.
// - the alarm appears on the open-collector output pair when it is set for overload and the relay is not selected.
// - the alarm goes to at most one of open-collector output or relay output.
// - open-collector output carries the alarm only while its function code is 5.
// - the warning never shuts the drive output off.
// - trip enable is one bit defaulting to 1 and only when set does overload trip.
// - with trip enabled the output turns off after excess current lasts the trip time.
// - trip level is settable 30 to 200 percent and defaults to 180 percent.
// - warning level is settable 30 to 150 percent and defaults to 150 percent.
// - trip time is settable 0 to 60 s, defaults to 60 s, and trips at or above level.
module mom_monitor
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [15:0] motor_current,
   input wire logic [15:0] rated_motor_current,
   input wire logic [7:0] overload_warn_level,
   input wire logic [4:0] overload_warn_hold_time,
   input wire logic overload_trip_enable,
   input wire logic [7:0] overload_trip_level,
   input wire logic [5:0] overload_trip_time,
   input wire logic [3:0] open_collector_output_function,
   input wire logic relay_select,
   input wire logic cfg_load,
   input wire logic factory_reset,
   input wire logic fault_reset,
   output logic open_collector_output,
   output logic relay_output,
   output logic overload_warning,
   output logic overload_trip,
   output logic drive_output_enable
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      mom_pkg::mom_cfg_t cfg;
      logic warn;
      logic [15:0] hold_cnt;
      logic [15:0] trip_cnt;
      logic trip;
      logic oc_out;
      logic relay;
      logic drv_en;
   } mom_st_t;

   localparam logic [15:0] TPS = 16'(mom_pkg::TICKS_PER_SEC);

   mom_st_t st;
   mom_st_t next_st;
   logic tick;

   // clamp a value into a range
   function automatic logic [7:0] mom_clamp8(input logic [7:0] v, input logic [7:0] lo,
                                             input logic [7:0] hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      return v;
   endfunction : mom_clamp8

   // true when current >= pct percent of rated
   function automatic logic mom_at_or_above(input logic [15:0] cur, input logic [15:0] rated,
                                            input logic [7:0] pct);
      logic [23:0] lhs;
      logic [23:0] rhs;
      lhs = {8'h00, cur} * 24'h000064;
      rhs = {8'h00, rated} * {16'h0000, pct};
      return lhs >= rhs;
   endfunction : mom_at_or_above

   // ------------------------------------------------------------
   // tick source
   // ------------------------------------------------------------
   // fixed periodic tick
   mom_tick u_tick
   (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .tick(tick)
   );

   logic warn_hit;
   logic trip_hit;
   logic [15:0] hold_ticks;
   logic [15:0] trip_ticks;

   assign warn_hit = mom_at_or_above(motor_current, rated_motor_current, st.cfg.warn_level);
   assign trip_hit = mom_at_or_above(motor_current, rated_motor_current, st.cfg.trip_level);
   assign hold_ticks = 16'({11'h000, st.cfg.hold_time} * TPS);
   assign trip_ticks = 16'({10'h000, st.cfg.trip_time} * TPS);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      if (factory_reset)
      begin
         next_st.cfg = mom_pkg::CFG_RST;
      end
      else if (cfg_load)
      begin
         next_st.cfg.warn_level = mom_clamp8(overload_warn_level, mom_pkg::WARN_LEVEL_MIN,
                                             mom_pkg::WARN_LEVEL_MAX);
         next_st.cfg.hold_time = (overload_warn_hold_time > mom_pkg::HOLD_TIME_MAX) ?
                                 mom_pkg::HOLD_TIME_MAX : overload_warn_hold_time;
         next_st.cfg.trip_enable = overload_trip_enable;
         next_st.cfg.trip_level = mom_clamp8(overload_trip_level, mom_pkg::TRIP_LEVEL_MIN,
                                             mom_pkg::TRIP_LEVEL_MAX);
         next_st.cfg.trip_time = (overload_trip_time > mom_pkg::TRIP_TIME_MAX) ?
                                 mom_pkg::TRIP_TIME_MAX : overload_trip_time;
         next_st.cfg.oc_func = open_collector_output_function;
         next_st.cfg.relay_sel = relay_select;
      end
      if (tick)
      begin
         if (warn_hit)
         begin
            next_st.warn = 1'b1;
            next_st.hold_cnt = '0;
         end
         else if (st.warn)
         begin
            if (st.hold_cnt >= hold_ticks)
               next_st.warn = 1'b0;
            else
               next_st.hold_cnt = st.hold_cnt + 16'h0001;
         end
         // trip at or above level for trip time
         if (trip_hit)
         begin
            if (st.trip_cnt >= trip_ticks)
            begin
               if (st.cfg.trip_enable)
                  next_st.trip = 1'b1;
            end
            else
            begin
               next_st.trip_cnt = st.trip_cnt + 16'h0001;
            end
         end
         else
         begin
            next_st.trip_cnt = '0;
         end
      end
      if (fault_reset && !(tick && trip_hit && st.cfg.trip_enable && st.trip_cnt >= trip_ticks))
      begin
         next_st.trip = 1'b0;
         next_st.trip_cnt = '0;
      end
      // open collector only with code 5
      next_st.oc_out = next_st.warn && !next_st.cfg.relay_sel &&
                       (next_st.cfg.oc_func == mom_pkg::OC_FUNC_OVERLOAD);
      next_st.relay = next_st.warn && next_st.cfg.relay_sel;
      // only the trip gates the drive
      next_st.drv_en = !next_st.trip;
   end

   // state register
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         st <= '0;
         st.cfg <= mom_pkg::CFG_RST;
         st.drv_en <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign open_collector_output = st.oc_out;
   assign relay_output = st.relay;
   assign overload_warning = st.warn;
   assign overload_trip = st.trip;
   assign drive_output_enable = st.drv_en;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_hold_range: assert property (st.cfg.hold_time <= 5'h1e)
      else $error("hold time out of range");
   chk_warn_raise: assert property (tick && warn_hit |=> st.warn)
      else $error("warning not raised");
   chk_warn_hold: assert property (st.warn && !warn_hit && tick && st.hold_cnt < hold_ticks
      |=> st.warn)
      else $error("warning dropped early");
   chk_warn_level: assert property (st.cfg.warn_level >= 8'h1e && st.cfg.warn_level <= 8'h96)
      else $error("warning level out of range");
   chk_oc_code: assert property (st.oc_out |-> st.cfg.oc_func == 4'h5)
      else $error("open collector without overload code");
   chk_one_term: assert property (!(st.oc_out && st.relay))
      else $error("alarm on both terminals");
   chk_warn_no_trip: assert property (!st.trip |-> st.drv_en)
      else $error("drive off without trip");
   chk_trip_enable: assert property (!st.cfg.trip_enable && !st.trip |=> !st.trip)
      else $error("trip while disabled");
   chk_trip_level: assert property (st.cfg.trip_level >= 8'h1e && st.cfg.trip_level <= 8'hc8)
      else $error("trip level out of range");
   chk_trip_latch: assert property (st.trip && !fault_reset |=> st.trip)
      else $error("trip not latched");
   chk_trip_off: assert property (st.trip |-> !st.drv_en)
      else $error("drive still on after trip");
   chk_trip_time: assert property (st.cfg.trip_time <= 6'h3c)
      else $error("trip time out of range");
   chk_tick_gap: assert property (tick |=> !tick)
      else $error("tick too close");

   cov_warn: cover property (st.warn ##1 !st.warn);
   cov_trip: cover property (!st.trip ##1 st.trip);
   cov_relay: cover property (st.relay);
   cov_reset: cover property (st.trip ##1 !st.trip);
endmodule : mom_monitor
`default_nettype wire

// file: test/mom_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// motor load model
// ------------------------------------------------------------
module mom_motor_model
(
   input wire logic core_clk,
   input wire logic drive_output_enable,
   input wire logic [15:0] rated_motor_current,
   input wire logic [7:0] load_pct,
   output logic [15:0] motor_current
);
   // current follows load while powered, falls to zero once output is cut
   always_ff @(posedge core_clk)
   begin
      if (drive_output_enable)
         motor_current <= 16'((32'(rated_motor_current) * 32'(load_pct)) / 100);
      else
         motor_current <= 16'h0000;
   end
endmodule : mom_motor_model
`default_nettype wire

// file: test/motor_overload_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module motor_overload_monitor_bench;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cfg_load = 1'b0;
   logic fault_reset = 1'b0;
   logic [15:0] motor_current;
   logic [15:0] rated = 16'h0064;
   logic [7:0] load = 8'h00;
   logic [7:0] warn_lvl = 8'h96;
   logic [7:0] trip_lvl = 8'hb4;
   logic [4:0] hold = 5'h0a;
   logic [3:0] func = 4'h5;
   logic relay_sel = 1'b0;
   logic factory_rst = 1'b0;
   logic trip_en = 1'b1;
   logic [5:0] trip_t = 6'h00;
   logic oc_out;
   logic relay_out;
   logic warn;
   logic trip;
   logic drv_en;
   int err_total = 0;
   int num_checks = 0;
   int waited = 0;

   always #4 core_clk = ~core_clk;

   mom_monitor u_dut (.core_clk(core_clk), .rst_b(rst_b), .motor_current(motor_current),
      .rated_motor_current(rated), .overload_warn_level(warn_lvl),
      .overload_warn_hold_time(hold), .overload_trip_enable(trip_en),
      .overload_trip_level(trip_lvl), .overload_trip_time(trip_t),
      .open_collector_output_function(func), .relay_select(relay_sel), .cfg_load(cfg_load),
      .factory_reset(factory_rst), .fault_reset(fault_reset), .open_collector_output(oc_out),
      .relay_output(relay_out), .overload_warning(warn), .overload_trip(trip),
      .drive_output_enable(drv_en));

   mom_motor_model u_motor (.core_clk(core_clk), .drive_output_enable(drv_en),
      .rated_motor_current(rated), .load_pct(load), .motor_current(motor_current));

   // compare one flag, count and report
   task automatic check(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : check

   // at-or-above comparison of model current against a percent level
   function automatic logic hit(input logic [15:0] r, input logic [7:0] l, input logic [7:0] p);
      logic [31:0] cur;
      cur = (32'(r) * 32'(l)) / 100;
      return (cur * 100) >= (32'(r) * 32'(p));
   endfunction : hit

   // verdict and end of run
   task automatic complete_run();
      if (err_total == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(88586));
      rated = 16'(100 * $urandom_range(50, 1));
      warn_lvl = 8'($urandom_range(150, 30));
      trip_lvl = 8'($urandom_range(200, 30));
      hold = 5'($urandom_range(30, 0));
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      @(negedge core_clk);
      check("trip_rst", 1'b0, trip);
      check("drv_rst", 1'b1, drv_en);
      check("warn_rst", 1'b0, warn);
      cfg_load = 1'b1;
      @(negedge core_clk);
      cfg_load = 1'b0;
      // corner: load sits exactly on the higher of the two levels
      load = (warn_lvl > trip_lvl) ? warn_lvl : trip_lvl;
      while (waited < 130000 && warn !== 1'b1)
      begin
         @(negedge core_clk);
         waited++;
      end
      check("tick_time", 1'b1, waited >= 124990 && waited <= 125000);
      check("warn_set", hit(rated, load, warn_lvl), warn);
      check("oc_out", 1'b1, oc_out);
      check("relay_out", 1'b0, relay_out);
      repeat (2) @(negedge core_clk);
      check("trip_set", hit(rated, load, trip_lvl), trip);
      check("drv_off", 1'b0, drv_en);
      repeat (5) @(negedge core_clk);
      check("trip_latch", 1'b1, trip);
      fault_reset = 1'b1;
      @(negedge core_clk);
      fault_reset = 1'b0;
      check("trip_clear", 1'b0, trip);
      check("drv_back", 1'b1, drv_en);
      check("warn_hold", 1'b1, warn);
      // corner: move the held alarm over to the relay
      relay_sel = 1'b1;
      cfg_load = 1'b1;
      @(negedge core_clk);
      cfg_load = 1'b0;
      check("relay_sel_on", 1'b1, relay_out);
      check("oc_sel_off", 1'b0, oc_out);
      // corner: factory defaults put function code 0 on the open collector
      relay_sel = 1'b0;
      factory_rst = 1'b1;
      @(negedge core_clk);
      factory_rst = 1'b0;
      check("oc_func_dflt", 1'b0, oc_out);
      check("relay_dflt", 1'b0, relay_out);
      check("warn_kept", 1'b1, warn);
      complete_run();
   end

   // hang guard
   initial
   begin
      repeat (140000) @(posedge core_clk);
      err_total++;
      complete_run();
   end
endmodule : motor_overload_monitor_bench
`default_nettype wire
